// *** shared/hbp_params.svh ***
// constants of the host bus port: widths, reset values and timing counts
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

`define HBP_ADDR_W        14
`define HBP_DATA_W        16
`define HBP_STREAMS       32
`define HBP_HIZ_OUTS      16
`define HBP_CLK_MHZ       40
`define HBP_SETTLE_US     600
`define HBP_SETTLE_CYC    (`HBP_SETTLE_US * `HBP_CLK_MHZ)
`define HBP_RST_MIN_US    1
`define HBP_RST_MIN_CYC   (`HBP_RST_MIN_US * `HBP_CLK_MHZ)
`define HBP_SETTLE_CNT_W  15
`define HBP_HIZ_RST_VAL   16'hFFFF
`define HBP_STRM_RST_VAL  32'h0000_0000

`endif

// *** shared/hbp_pkg.sv ***
// types of the host bus port
package hbp_pkg;

    // access sequencer states
    typedef enum logic [1:0] {
        HBP_IDLE,
        HBP_WAIT,
        HBP_DONE
    } hbp_state_t;

endpackage

// *** shared/hbp_pin_if.sv ***
// synchronised host pins passed from the synchroniser to the port logic
`timescale 1ns/1ps
`include "hbp_params.svh"

interface hbp_pin_if;
    logic                   cs_n;
    logic                   strobe_n;   // data strobe or read strobe
    logic                   rw_n;       // direction or write strobe
    logic                   style;      // high: strobe style
    logic                   rst_n;      // device reset pin
    logic [`HBP_ADDR_W-1:0] addr;
    logic [`HBP_DATA_W-1:0] data;

    modport sync (output cs_n, strobe_n, rw_n, style, rst_n, addr, data);
    modport port (input  cs_n, strobe_n, rw_n, style, rst_n, addr, data);
endinterface

// *** design/hbp_sync.sv ***
// two-stage synchroniser for every host pin input
`timescale 1ns/1ps
`include "hbp_params.svh"

module hbp_sync (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // raw pins
    input  wire logic                   cs_n,
    input  wire logic                   strobe_n,
    input  wire logic                   rw_n,
    input  wire logic                   style,
    input  wire logic                   rst_n,
    input  wire logic [`HBP_ADDR_W-1:0] addr,
    input  wire logic [`HBP_DATA_W-1:0] data,
    // synchronised pins
    hbp_pin_if.sync                     pins
);

    localparam int W = 5 + `HBP_ADDR_W + `HBP_DATA_W;
    // idle level: controls high, bus low
    localparam logic [W-1:0] IDLE_VAL =
        {5'h1F, {(`HBP_ADDR_W + `HBP_DATA_W){1'b0}}};

    typedef struct packed {
        logic [W-1:0] s1;   // first stage, read only by s2
        logic [W-1:0] s2;
    } hbp_sync_st_t;

    hbp_sync_st_t st_r;
    hbp_sync_st_t st_nxt;

    // shift pins through two stages
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = {cs_n, strobe_n, rw_n, style, rst_n, addr, data};
        st_nxt.s2 = st_r.s1;
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{s1: IDLE_VAL, s2: IDLE_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    // unpack second stage
    assign {pins.cs_n, pins.strobe_n, pins.rw_n, pins.style, pins.rst_n,
            pins.addr, pins.data} = st_r.s2;

endmodule // hbp_sync

// *** design/hbp_port.sv ***
// non-multiplexed 16-bit host bus port with device reset handling
// Behaviour
// - In strobe-style mode the port drives the acknowledge low when a transfer completes.
// - In separate-strobe mode completion is a low-to-high edge on the ready output.
// - Every access opens with chip select low; the port ignores the bus while it is high.
// - In separate-strobe mode a low write strobe is taken as a write access.
// - In strobe-style mode an access runs only while data strobe and chip select are both low.
// - In separate-strobe mode a low read strobe is taken as a read access.
// - A 14-bit host address selects the internal memory location or register.
// - A high or open style select input, pulled up, gives strobe-style mode.
// - A grounded style select input gives separate-strobe mode.
// - While reset is low all serial stream drivers are off and all sixteen high-impedance controls are high.
// - Reset loads register defaults and clears every internal counter.
// - Data moves over a 16-bit two-way data bus.
`timescale 1ns/1ps
`include "hbp_params.svh"

module hbp_port #(
    parameter int ADDR_W     = `HBP_ADDR_W,
    parameter int DATA_W     = `HBP_DATA_W,
    parameter int SETTLE_CYC = `HBP_SETTLE_CYC
) (
    // clock and reset
    clk,
    sys_rst,
    // host control pins
    cs_n,
    data_strobe_or_read_strobe_n,
    rw_or_write_strobe_n,
    bus_style_select,
    dev_rst_n,
    port_address,
    // data bus, three signals
    port_data_bus_i,
    port_data_bus_o,
    port_data_bus_oe,
    // acknowledge or ready, two signals
    transfer_ack_ready_o,
    transfer_ack_ready_oe,
    // datapath side
    stream_oe_req,
    hiz_req,
    serial_output_streams_oe,
    external_hiz_controls,
    // internal memory and register side
    core_rst,
    acc_valid,
    acc_write,
    acc_addr,
    acc_wdata,
    acc_rdata,
    acc_done,
    settled
);

    // clock and reset
    input  wire logic                    clk;
    input  wire logic                    sys_rst;
    // host control pins
    input  wire logic                    cs_n;
    input  wire logic                    data_strobe_or_read_strobe_n;
    input  wire logic                    rw_or_write_strobe_n;
    input  wire logic                    bus_style_select;
    input  wire logic                    dev_rst_n;
    input  wire logic [ADDR_W-1:0]       port_address;
    // data bus
    input  wire logic [DATA_W-1:0]       port_data_bus_i;
    output      logic [DATA_W-1:0]       port_data_bus_o;
    output      logic                    port_data_bus_oe;
    // acknowledge or ready
    output      logic                    transfer_ack_ready_o;
    output      logic                    transfer_ack_ready_oe;
    // datapath side
    input  wire logic [`HBP_STREAMS-1:0] stream_oe_req;
    input  wire logic [`HBP_HIZ_OUTS-1:0] hiz_req;
    output      logic [`HBP_STREAMS-1:0] serial_output_streams_oe;
    output      logic [`HBP_HIZ_OUTS-1:0] external_hiz_controls;
    // internal memory and register side
    output      logic                    core_rst;
    output      logic                    acc_valid;
    output      logic                    acc_write;
    output      logic [ADDR_W-1:0]       acc_addr;
    output      logic [DATA_W-1:0]       acc_wdata;
    input  wire logic [DATA_W-1:0]       acc_rdata;
    input  wire logic                    acc_done;
    output      logic                    settled;

    localparam logic [`HBP_SETTLE_CNT_W-1:0] SETTLE_LAST =
        `HBP_SETTLE_CNT_W'(SETTLE_CYC - 1);

    //--------------------------------------------------------------------
    // pin synchronisation
    //--------------------------------------------------------------------

    hbp_pin_if pins ();

    hbp_sync u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .cs_n     (cs_n),
        .strobe_n (data_strobe_or_read_strobe_n),
        .rw_n     (rw_or_write_strobe_n),
        .style    (bus_style_select),
        .rst_n    (dev_rst_n),
        .addr     (port_address),
        .data     (port_data_bus_i),
        .pins     (pins)
    );

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------

    typedef struct packed {
        hbp_pkg::hbp_state_t          state;
        logic                         write;
        logic [ADDR_W-1:0]            addr;
        logic [DATA_W-1:0]            wdata;
        logic [DATA_W-1:0]            rdata;
        logic                         req;
        logic                         in_rst;
        logic [`HBP_SETTLE_CNT_W-1:0] settle_cnt;
        logic                         settled;
    } hbp_port_st_t;

    hbp_port_st_t st_r;
    hbp_port_st_t st_nxt;

    logic dev_rst;
    logic strobe_mode;
    logic access;
    logic is_write;

    // reset from either the system or the device reset pin
    assign dev_rst     = sys_rst | ~pins.rst_n;
    // pulled-up select high gives strobe style, grounded gives separate
    assign strobe_mode = pins.style;

    // decode an open access and its direction from the strobes
    always_comb begin
        if (strobe_mode) begin
            access   = ~pins.cs_n & ~pins.strobe_n;
            is_write = ~pins.rw_n;
        end else begin
            access   = ~pins.cs_n & (~pins.strobe_n | ~pins.rw_n);
            is_write = ~pins.rw_n;
        end
    end

    //--------------------------------------------------------------------
    // access sequencer and settle counter
    //--------------------------------------------------------------------

    // next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.req    = 1'b0;
        st_nxt.in_rst = dev_rst;
        if (!st_r.settled) begin
            if (st_r.settle_cnt == SETTLE_LAST) begin
                st_nxt.settled = 1'b1;
            end else begin
                st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
            end
        end
        unique case (st_r.state)
            hbp_pkg::HBP_IDLE: begin
                if (access) begin
                    st_nxt.write = is_write;
                    st_nxt.addr  = pins.addr;
                    st_nxt.wdata = pins.data;
                    st_nxt.req   = 1'b1;
                    st_nxt.state = hbp_pkg::HBP_WAIT;
                end
            end
            hbp_pkg::HBP_WAIT: begin
                if (acc_done) begin
                    st_nxt.rdata = acc_rdata;
                    st_nxt.state = hbp_pkg::HBP_DONE;
                end
            end
            hbp_pkg::HBP_DONE: begin
                if (!access) begin                           // host ends cycle
                    st_nxt.state = hbp_pkg::HBP_IDLE;
                end
            end
        endcase
        if (dev_rst) begin
            // defaults and cleared counters
            st_nxt.state      = hbp_pkg::HBP_IDLE;
            st_nxt.write      = 1'b0;
            st_nxt.addr       = '0;
            st_nxt.wdata      = '0;
            st_nxt.rdata      = '0;
            st_nxt.req        = 1'b0;
            st_nxt.settle_cnt = '0;
            st_nxt.settled    = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{state: hbp_pkg::HBP_IDLE, write: 1'b0, addr: '0,
                      wdata: '0, rdata: '0, req: 1'b0, in_rst: 1'b1,
                      settle_cnt: '0, settled: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------------
    // pin and core outputs
    //--------------------------------------------------------------------

    // read data driven only through a selected read
    assign port_data_bus_o  = st_r.rdata;
    assign port_data_bus_oe = ~st_r.write & ~st_r.in_rst
        & (st_r.state == hbp_pkg::HBP_DONE);

    // strobe style: low at completion; separate: low, then high at end
    always_comb begin
        transfer_ack_ready_o  = 1'b1;
        transfer_ack_ready_oe = 1'b0;
        if (!st_r.in_rst && st_r.state != hbp_pkg::HBP_IDLE) begin
            if (strobe_mode) begin
                transfer_ack_ready_o  = 1'b0;
                transfer_ack_ready_oe = (st_r.state == hbp_pkg::HBP_DONE);
            end else begin
                transfer_ack_ready_o  =
                    (st_r.state == hbp_pkg::HBP_DONE);
                transfer_ack_ready_oe = 1'b1;
            end
        end
    end

    // serial drivers off and high-impedance controls high during reset
    assign serial_output_streams_oe =
        st_r.in_rst ? `HBP_STRM_RST_VAL : stream_oe_req;
    assign external_hiz_controls    =
        st_r.in_rst ? `HBP_HIZ_RST_VAL : hiz_req;

    // core access request
    assign core_rst  = st_r.in_rst;
    assign acc_valid = st_r.req;
    assign acc_write = st_r.write;
    assign acc_addr  = st_r.addr;
    assign acc_wdata = st_r.wdata;
    assign settled   = st_r.settled;

endmodule // hbp_port

// *** tb/hbp_port_sva.sv ***
// assertions on the host bus port pins
`timescale 1ns/1ps
`include "hbp_params.svh"
module hbp_port_sva (
    // clock and resets
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire logic                     dev_rst_n,
    // host pins
    input wire logic                     cs_n,
    input wire logic                     rw_or_write_strobe_n,
    input wire logic                     bus_style_select,
    input wire logic [`HBP_ADDR_W-1:0]   port_address,
    input wire logic [`HBP_DATA_W-1:0]   port_data_bus_i,
    input wire logic [`HBP_DATA_W-1:0]   port_data_bus_o,
    input wire logic                     port_data_bus_oe,
    input wire logic                     transfer_ack_ready_o,
    input wire logic                     transfer_ack_ready_oe,
    // datapath and core side
    input wire logic [`HBP_STREAMS-1:0]  serial_output_streams_oe,
    input wire logic [`HBP_HIZ_OUTS-1:0] external_hiz_controls,
    input wire logic                     acc_valid,
    input wire logic                     acc_write,
    input wire logic [`HBP_ADDR_W-1:0]   acc_addr,
    input wire logic [`HBP_DATA_W-1:0]   acc_wdata,
    input wire logic [`HBP_DATA_W-1:0]   acc_rdata,
    input wire logic                     acc_done
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // chip select held high long enough to pass the synchroniser
    sequence quiet_s;
        cs_n [*5];
    endsequence
    hiz_rst_a: assert property (disable iff (1'b0)
        sys_rst ##1 sys_rst |-> external_hiz_controls == 16'hFFFF)
        else $error("hiz controls not high in reset");
    streams_rst_a: assert property (
        !dev_rst_n [*5] |-> serial_output_streams_oe == 32'h0)
        else $error("stream drivers on during reset");
    ack_low_a: assert property (
        bus_style_select && $rose(transfer_ack_ready_oe)
        |-> !transfer_ack_ready_o && $past(acc_done))
        else $error("acknowledge not low after completion");
    ready_rise_a: assert property (
        !bus_style_select && acc_done && transfer_ack_ready_oe
        && !transfer_ack_ready_o |=> transfer_ack_ready_o)
        else $error("ready did not rise on completion");
    cs_quiet_a: assert property (quiet_s |-> !acc_valid)
        else $error("access taken without chip select");
    bus_release_a: assert property (quiet_s |-> !port_data_bus_oe)
        else $error("data bus driven while not selected");
    dir_a: assert property (
        acc_valid |-> acc_write == !$past(rw_or_write_strobe_n, 3))
        else $error("access direction wrong");
    addr_a: assert property (
        acc_valid |-> acc_addr == $past(port_address, 3))
        else $error("access address wrong");
    wdata_a: assert property (
        acc_valid && acc_write |-> acc_wdata == $past(port_data_bus_i, 3))
        else $error("write data wrong");
    drive_a: assert property (
        $rose(port_data_bus_oe)
        |-> !acc_write && port_data_bus_o == $past(acc_rdata))
        else $error("data bus driven wrongly");
endmodule // hbp_port_sva

bind hbp_port hbp_port_sva hbp_port_sva_i (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .dev_rst_n                (dev_rst_n),
    .cs_n                     (cs_n),
    .rw_or_write_strobe_n     (rw_or_write_strobe_n),
    .bus_style_select         (bus_style_select),
    .port_address             (port_address),
    .port_data_bus_i          (port_data_bus_i),
    .port_data_bus_o          (port_data_bus_o),
    .port_data_bus_oe         (port_data_bus_oe),
    .transfer_ack_ready_o     (transfer_ack_ready_o),
    .transfer_ack_ready_oe    (transfer_ack_ready_oe),
    .serial_output_streams_oe (serial_output_streams_oe),
    .external_hiz_controls    (external_hiz_controls),
    .acc_valid                (acc_valid),
    .acc_write                (acc_write),
    .acc_addr                 (acc_addr),
    .acc_wdata                (acc_wdata),
    .acc_rdata                (acc_rdata),
    .acc_done                 (acc_done)
);

// *** tb/hbp_host_model.sv ***
// host processor model driving the port pins
`timescale 1ns/1ps
`include "hbp_params.svh"
module hbp_host_model (
    // clock and pin levels seen
    input  wire logic                   clk,
    input  wire logic                   style,
    input  wire logic                   ack_pin,
    input  wire logic [`HBP_DATA_W-1:0] bus,
    // pins driven
    output logic                        cs_n,
    output logic                        ds_n,
    output logic                        rw_n,
    output logic [`HBP_ADDR_W-1:0]      addr,
    output logic [`HBP_DATA_W-1:0]      dout,
    output logic                        doe
);
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        ds_n = 1'b1;
        rw_n = 1'b1;
        addr = 14'h0000;
        dout = 16'h0000;
        doe  = 1'b0;
    end
    // one whole access, held until completion is seen or 60 cycles pass
    task automatic access(input logic we, input logic [13:0] a,
                          input logic [15:0] wd,
                          output logic [15:0] rd, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(negedge clk);
        addr = a;
        dout = wd;
        doe  = we;
        cs_n = 1'b0;
        rw_n = !we;
        ds_n = style ? 1'b0 : we;
        while (!ok && n < 60) begin
            @(posedge clk);
            ok = (ack_pin != style);
            n++;
        end
        rd = bus;
        @(negedge clk);
        cs_n = 1'b1;
        ds_n = 1'b1;
        rw_n = 1'b1;
        doe  = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // strobes toggled while not selected
    task automatic strobe_unselected;
        @(negedge clk);
        ds_n = 1'b0;
        rw_n = 1'b0;
        repeat (8) @(negedge clk);
        ds_n = 1'b1;
        rw_n = 1'b1;
    endtask
endmodule // hbp_host_model

// *** tb/host_bus_port_and_reset_tb.sv ***
// self-checking bench of the host bus port
`timescale 1ns/1ps
`include "hbp_params.svh"
module host_bus_port_and_reset_tb;
    typedef struct packed {
        logic        st;
        logic        we;
        logic [13:0] a;
        logic [15:0] d;
    } hbp_row_t;
    logic clk = 1'b0, sys_rst, dev_rst_n, style, cs_n, ds_n, rw_n, hoe;
    logic dboe, ako, akoe, core_rst, acc_valid, acc_write, settled, ok;
    logic acc_done = 1'b0, cap_we = 1'b0;
    logic [13:0] addr, acc_addr, cap_a = 14'h0000;
    logic [15:0] hd, dbo, acc_wdata, rd, cap_d = 16'h0000;
    logic [15:0] acc_rdata = 16'h0000, hiz_req, hiz;
    logic [31:0] soe_req, soe;
    int fails = 0, check_count = 0, nacc = 0, cyc = 0, n0;
    // bus level: released lines show a moving pattern
    wire [15:0] bus = dboe ? dbo : hoe ? hd : cyc[15:0];
    wire ack_pin = akoe ? ako : style; // pull-up or pull-down
    // d: write data, or the read data that the core model returns
    hbp_row_t rows [6] = '{'{1'b1, 1'b1, 14'h3FFF, 16'hA5C3},
        '{1'b1, 1'b0, 14'h3FFF, 16'h65A5}, '{1'b0, 1'b1, 14'h0000, 16'h5A3C},
        '{1'b0, 1'b0, 14'h0000, 16'h5A5A}, '{1'b1, 1'b0, 14'h1555, 16'h4F0F},
        '{1'b0, 1'b1, 14'h2AAA, 16'hFFFF}};
    always #12.5 clk = ~clk;
    hbp_port #(.SETTLE_CYC(20)) hbp_port_i (.clk(clk), .sys_rst(sys_rst),
        .cs_n(cs_n), .data_strobe_or_read_strobe_n(ds_n),
        .rw_or_write_strobe_n(rw_n), .bus_style_select(style),
        .dev_rst_n(dev_rst_n), .port_address(addr), .port_data_bus_i(bus),
        .port_data_bus_o(dbo), .port_data_bus_oe(dboe),
        .transfer_ack_ready_o(ako), .transfer_ack_ready_oe(akoe),
        .stream_oe_req(soe_req), .hiz_req(hiz_req),
        .serial_output_streams_oe(soe), .external_hiz_controls(hiz),
        .core_rst(core_rst), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_done(acc_done), .settled(settled));
    hbp_host_model hbp_host_model_i (.clk(clk), .style(style),
        .ack_pin(ack_pin), .bus(bus), .cs_n(cs_n), .ds_n(ds_n), .rw_n(rw_n),
        .addr(addr), .dout(hd), .doe(hoe));
    // core answers within the request's cycle, and a cycle watchdog
    always @(negedge clk) begin
        acc_done <= acc_valid;
        acc_rdata <= {2'h0, acc_addr} ^ 16'h5A5A;
        cyc <= cyc + 1;
        if (acc_valid) begin
            nacc <= nacc + 1;
            cap_a <= acc_addr;
            cap_d <= acc_wdata;
            cap_we <= acc_write;
        end
        if (cyc == 3000) begin
            fails++;
            finish_test;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        dev_rst_n = 1'b1;
        style = 1'b1;
        hiz_req = 16'h1234;
        soe_req = 32'hF0F0_0F0F;
        repeat (12) @(negedge clk);
        check(hiz, 16'hFFFF);
        sys_rst = 1'b0;
        repeat (30) @(negedge clk); // settling wait, scaled
        check(settled, 1'b1);
        $display("system reset test done");
        foreach (rows[i]) begin
            style = rows[i].st;
            repeat (4) @(negedge clk);
            hbp_host_model_i.access(rows[i].we, rows[i].a, rows[i].d, rd, ok);
            check(ok, 1'b1);
            check(cap_we, rows[i].we);
            check(cap_a, rows[i].a);
            if (rows[i].we) check(cap_d, rows[i].d);
            else check(rd, rows[i].d);
            $display("row %0d done", i);
        end
        n0 = nacc;
        hbp_host_model_i.strobe_unselected();
        repeat (4) @(negedge clk);
        check(nacc, n0);
        $display("unselected strobe test done");
        dev_rst_n = 1'b0;
        repeat (45) @(negedge clk); // longer than one microsecond
        check({hiz, soe}, {16'hFFFF, 32'h0});
        check({core_rst, settled}, 2'b10);
        dev_rst_n = 1'b1;
        repeat (30) @(negedge clk);
        check({hiz, soe}, {hiz_req, soe_req});
        hbp_host_model_i.access(1'b0, 14'h0ABC, 16'h0000, rd, ok);
        check(rd, 16'h50E6);
        $display("device reset test done");
        finish_test;
    end
endmodule // host_bus_port_and_reset_tb
